// *** core/mgmt_serial_slave.sv ***
`timescale 1ns/10ps
module mgmt_serial_slave import phy_rst_pkg::*; (
	input  wire logic        sys_clk_in,
	input  wire logic        reset_n_in,
	input  wire logic [4:0]  phy_addr_in,
	input  wire logic        mdc_in,
	input  wire logic        mdio_in,
	output logic             mdio_out,
	output logic             mdio_oe_out,
	output logic [4:0]       reg_addr_out,
	output logic [15:0]      reg_wdata_out,
	output logic             reg_wr_out,
	output logic             reg_rd_out,
	input  wire logic [15:0] reg_rdata_in
);

	// ==========================================================================
	// Frame decoder
	// ==========================================================================
	// The management clock is sampled on the system clock, so it must be slower
	// than half the system clock rate.
	mgmt_state_e state;
	logic        mdc_q;
	logic        prev_bit;
	logic [4:0]  bit_cnt;
	logic [11:0] hdr;
	logic [15:0] data_sh;
	logic        is_read;
	logic        is_write;
	logic        mdc_rise;
	logic [11:0] next_hdr;

	assign mdc_rise = mdc_in & ~mdc_q;
	assign next_hdr = {hdr[10:0], mdio_in};

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			mdc_q <= 1'b0;
		end else begin
			mdc_q <= mdc_in;
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state         <= MGMT_IDLE;
			prev_bit      <= 1'b1;
			bit_cnt       <= 5'h00;
			hdr           <= 12'h000;
			data_sh       <= 16'h0000;
			is_read       <= 1'b0;
			is_write      <= 1'b0;
			mdio_out      <= 1'b0;
			mdio_oe_out   <= 1'b0;
			reg_addr_out  <= 5'h00;
			reg_wdata_out <= 16'h0000;
			reg_wr_out    <= 1'b0;
			reg_rd_out    <= 1'b0;
		end else begin
			reg_wr_out <= 1'b0;
			reg_rd_out <= 1'b0;
			if (reg_rd_out) begin
				data_sh <= reg_rdata_in;
			end
			if (mdc_rise) begin
				case (state)
					MGMT_IDLE: begin
						// A frame opens only on a fresh 0-then-1 start pattern, so a line left idle after reset is safe.
						prev_bit <= mdio_in;
						if (!prev_bit && mdio_in) begin
							state   <= MGMT_FRAME;
							bit_cnt <= 5'h00;
						end
					end
					MGMT_FRAME: begin
						bit_cnt <= bit_cnt + 5'h01;
						if (bit_cnt <= MGMT_HDR_LAST) begin
							hdr <= next_hdr;
						end
						if (bit_cnt == MGMT_HDR_LAST) begin
							is_read      <= (next_hdr[11:10] == MGMT_OP_READ) && (next_hdr[9:5] == phy_addr_in);
							is_write     <= (next_hdr[11:10] == MGMT_OP_WRITE) && (next_hdr[9:5] == phy_addr_in);
							reg_addr_out <= next_hdr[4:0];
							reg_rd_out   <= (next_hdr[11:10] == MGMT_OP_READ) && (next_hdr[9:5] == phy_addr_in);
						end
						if (is_read && bit_cnt == MGMT_TA_FIRST) begin
							mdio_oe_out <= 1'b1;
							mdio_out    <= 1'b0;
						end else if (is_read && bit_cnt > MGMT_TA_FIRST && bit_cnt <= MGMT_DATA_LAST) begin
							mdio_out <= data_sh[15];
							data_sh  <= {data_sh[14:0], 1'b0};
						end else if (is_write && bit_cnt > MGMT_TA_FIRST + 5'h01) begin
							data_sh <= {data_sh[14:0], mdio_in};
						end
						if (bit_cnt == MGMT_FRAME_END) begin
							state       <= MGMT_IDLE;
							prev_bit    <= 1'b1;
							mdio_oe_out <= 1'b0;
							is_read     <= 1'b0;
							is_write    <= 1'b0;
							if (is_write) begin
								reg_wdata_out <= {data_sh[14:0], mdio_in};
								reg_wr_out    <= 1'b1;
							end
						end
					end
					default: begin
						state <= MGMT_IDLE;
					end
				endcase
			end
		end
	end

endmodule

// *** core/phy_reset_powerdown_interrupt.sv ***
`timescale 1ns/10ps
module phy_reset_powerdown_interrupt import phy_rst_pkg::*; #(
	parameter int SETTLE_CYCLES = SETTLE_DEF_CYCLES
) (
	input  wire logic        sys_clk_in,
	input  wire logic        reset_n_in,
	input  wire logic        hw_reset_n_in,
	input  wire logic [4:0]  strap_in,
	input  wire logic        mdc_in,
	input  wire logic        mdio_in,
	output logic             mdio_out,
	output logic             mdio_oe_out,
	input  wire logic [15:0] irq_src_in,
	input  wire logic        irq_pin_in,
	output logic             irq_pin_out,
	output logic             irq_pin_oe_out,
	output logic             core_reset_out,
	output logic             powerdown_out,
	output logic             low_power_active_out,
	output logic             low_power_passive_out,
	output logic [4:0]       strap_out
);

	// ==========================================================================
	// Management access
	// ==========================================================================
	logic [4:0]  reg_addr;
	logic [15:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_rdata;

	mgmt_serial_slave u_mgmt (
		.sys_clk_in    (sys_clk_in),
		.reset_n_in    (reset_n_in),
		.phy_addr_in   (strap_out),
		.mdc_in        (mdc_in),
		.mdio_in       (mdio_in),
		.mdio_out      (mdio_out),
		.mdio_oe_out   (mdio_oe_out),
		.reg_addr_out  (reg_addr),
		.reg_wdata_out (reg_wdata),
		.reg_wr_out    (reg_wr),
		.reg_rd_out    (reg_rd),
		.reg_rdata_in  (reg_rdata)
	);

	// ==========================================================================
	// Reset sequencer
	// ==========================================================================
	seq_state_e  state;
	logic [4:0]  hw_low_cnt;
	logic [12:0] settle_cnt;
	logic        hw_hit;
	logic        glob_write;
	logic        restart_write;
	logic        sw_go;
	logic        soft_rst_write;
	logic        regs_default;
	logic        strap_armed;

	localparam logic [4:0]  HW_LAST     = 5'(HW_PULSE_MIN_CYCLES - 1);
	localparam logic [12:0] SETTLE_LAST = 13'(SETTLE_CYCLES - 1);

	assign glob_write      = reg_wr && reg_addr == ADDR_PHY_RESET_CONTROL && reg_wdata[RCR_GLOBAL_RESET_BIT];
	assign restart_write   = reg_wr && reg_addr == ADDR_PHY_RESET_CONTROL && reg_wdata[RCR_RESTART_BIT];
	assign soft_rst_write  = reg_wr && reg_addr == ADDR_BASIC_MODE_CONTROL && reg_wdata[BMC_SOFT_RESET_BIT];
	assign sw_go           = glob_write || restart_write;
	// A low shorter than the minimum pulse is ignored as a glitch.
	assign hw_hit          = !hw_reset_n_in && hw_low_cnt == HW_LAST;
	assign regs_default    = (state == SEQ_HW_HOLD) || glob_write;
	assign core_reset_out  = (state != SEQ_RUN);

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			hw_low_cnt <= 5'h00;
		end else if (hw_reset_n_in) begin
			hw_low_cnt <= 5'h00;
		end else if (hw_low_cnt != HW_LAST) begin
			hw_low_cnt <= hw_low_cnt + 5'h01;
		end
	end

	// The power-on reset alone brings every flop to a working state.
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state      <= SEQ_RUN;
			settle_cnt <= 13'h0000;
		end else begin
			case (state)
				SEQ_RUN: begin
					if (hw_hit) begin
						state <= SEQ_HW_HOLD;
					end else if (sw_go) begin
						state      <= SEQ_SETTLE;
						settle_cnt <= SETTLE_LAST;
					end
				end
				SEQ_HW_HOLD: begin
					if (hw_reset_n_in) begin
						state      <= SEQ_SETTLE;
						settle_cnt <= SETTLE_LAST;
					end
				end
				SEQ_SETTLE: begin
					if (hw_hit) begin
						state <= SEQ_HW_HOLD;
					end else if (sw_go) begin
						settle_cnt <= SETTLE_LAST;
					end else if (settle_cnt == 13'h0000) begin
						state <= SEQ_RUN;
					end else begin
						settle_cnt <= settle_cnt - 13'h0001;
					end
				end
				default: begin
					state <= SEQ_RUN;
				end
			endcase
		end
	end

	// Straps are caught by a clocked process after reset release, never under the reset itself.
	// A global software reset does not arm this, so it keeps the old values.
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			strap_armed <= 1'b1;
			strap_out   <= STRAP_RESET;
		end else if (state == SEQ_HW_HOLD) begin
			strap_armed <= 1'b1;
		end else if (strap_armed) begin
			strap_armed <= 1'b0;
			strap_out   <= strap_in;
		end
	end

	// ==========================================================================
	// Registers
	// ==========================================================================
	logic [15:0] basic_mode_control;
	logic [15:0] phy_special_control;
	logic [13:0] rcr_spare;
	logic [15:0] irq_enable;
	logic [15:0] irq_status;
	logic        wr_ok;

	assign wr_ok = reg_wr && state != SEQ_HW_HOLD;

	// The soft reset bit clears only this register; it is the sole standard register held here.
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			basic_mode_control <= BMC_RESET_VALUE;
		end else if (regs_default || soft_rst_write) begin
			basic_mode_control <= BMC_RESET_VALUE;
		end else if (wr_ok && reg_addr == ADDR_BASIC_MODE_CONTROL) begin
			basic_mode_control <= {1'b0, reg_wdata[14:0]};
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			phy_special_control <= SCR_RESET_VALUE;
			rcr_spare           <= RCR_RESET_VALUE[13:0];
		end else if (regs_default) begin
			phy_special_control <= SCR_RESET_VALUE;
			rcr_spare           <= RCR_RESET_VALUE[13:0];
		end else if (wr_ok && reg_addr == ADDR_PHY_SPECIAL_CONTROL) begin
			phy_special_control <= reg_wdata;
		end else if (wr_ok && reg_addr == ADDR_PHY_RESET_CONTROL) begin
			rcr_spare <= reg_wdata[13:0];
		end
	end

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			irq_enable <= IRQ_EN_RESET;
		end else if (regs_default) begin
			irq_enable <= IRQ_EN_RESET;
		end else if (wr_ok && reg_addr == ADDR_IRQ_STATUS_ONE) begin
			irq_enable[7:0] <= reg_wdata[7:0];
		end else if (wr_ok && reg_addr == ADDR_IRQ_STATUS_TWO) begin
			irq_enable[15:8] <= reg_wdata[7:0];
		end
	end

	// Sticky status per source; an event in the same cycle as the clearing read survives.
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_status
			logic rd_clear;
			assign rd_clear = reg_rd && reg_addr == (gi < 8 ? ADDR_IRQ_STATUS_ONE : ADDR_IRQ_STATUS_TWO);
			always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
				if (!reset_n_in) begin
					irq_status[gi] <= 1'b0;
				end else if (regs_default) begin
					irq_status[gi] <= 1'b0;
				end else if (irq_src_in[gi] && irq_enable[gi]) begin
					irq_status[gi] <= 1'b1;
				end else if (rd_clear) begin
					irq_status[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	always_comb begin
		case (reg_addr)
			ADDR_BASIC_MODE_CONTROL:  reg_rdata = basic_mode_control;
			ADDR_PHY_SPECIAL_CONTROL: reg_rdata = phy_special_control;
			ADDR_IRQ_STATUS_ONE:      reg_rdata = {irq_status[7:0], irq_enable[7:0]};
			ADDR_IRQ_STATUS_TWO:      reg_rdata = {irq_status[15:8], irq_enable[15:8]};
			ADDR_PHY_RESET_CONTROL:   reg_rdata = {2'b00, rcr_spare};
			default:                  reg_rdata = 16'h0000;
		endcase
	end

	// ==========================================================================
	// Shared interrupt and power-down pin
	// ==========================================================================
	// The live source term bypasses the status flops so the pin moves without a clock.
	logic irq_active;
	logic pin_powerdown;

	assign irq_active     = phy_special_control[SCR_INT_EN_BIT] && (|irq_status || |(irq_src_in & irq_enable));
	assign irq_pin_oe_out = phy_special_control[SCR_INT_OE_BIT];
	assign irq_pin_out    = phy_special_control[SCR_INT_POL_BIT] ? irq_active : ~irq_active;
	assign pin_powerdown  = !phy_special_control[SCR_INT_OE_BIT] && !irq_pin_in;

	// ==========================================================================
	// Power modes
	// ==========================================================================
	// Nothing is torn down on entry, so clearing the request simply resumes where the core was.
	logic [1:0] psave_sel;
	logic       next_powerdown;

	assign psave_sel      = phy_special_control[SCR_PSAVE_SEL_LSB +: 2];
	assign next_powerdown = pin_powerdown || basic_mode_control[BMC_POWER_DOWN_BIT] ||
		(phy_special_control[SCR_PSAVE_EN_BIT] && psave_sel == PSAVE_POWER_DOWN);

	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			powerdown_out         <= 1'b0;
			low_power_active_out  <= 1'b0;
			low_power_passive_out <= 1'b0;
		end else begin
			powerdown_out         <= next_powerdown;
			low_power_active_out  <= !next_powerdown && phy_special_control[SCR_PSAVE_EN_BIT] &&
				psave_sel == PSAVE_ACTIVE;
			low_power_passive_out <= !next_powerdown && phy_special_control[SCR_PSAVE_EN_BIT] &&
				psave_sel == PSAVE_PASSIVE;
		end
	end

	// ==========================================================================
	// Checks
	// ==========================================================================
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);

	sequence glob_write_s;
		glob_write;
	endsequence

	sequence restart_only_s;
		restart_write && !glob_write && !hw_hit;
	endsequence

	hw_hold_entry_a: assert property (hw_hit |=> state == SEQ_HW_HOLD)
		else $error("reset pin pulse did not enter hold");
	hw_defaults_a: assert property (state == SEQ_HW_HOLD |=> phy_special_control == SCR_RESET_VALUE && irq_enable == IRQ_EN_RESET)
		else $error("hardware reset left a register set");
	hw_release_a: assert property ((state == SEQ_HW_HOLD && hw_reset_n_in) |=> state == SEQ_SETTLE && settle_cnt == SETTLE_LAST)
		else $error("hardware reset release did not start settling");
	settle_end_a: assert property ((state == SEQ_SETTLE && settle_cnt == 13'h0000 && !hw_hit && !sw_go) |=> state == SEQ_RUN)
		else $error("settle did not end on count");
	soft_only_a: assert property ((soft_rst_write && !regs_default) |=> basic_mode_control == BMC_RESET_VALUE && $stable(phy_special_control))
		else $error("soft reset touched other registers");
	global_regs_a: assert property (glob_write_s |=> phy_special_control == SCR_RESET_VALUE && irq_enable == IRQ_EN_RESET && $stable(strap_out))
		else $error("global reset wrong");
	restart_keep_a: assert property ((restart_only_s and (state != SEQ_HW_HOLD)) |=> $stable(phy_special_control) && $stable(irq_enable) && state == SEQ_SETTLE)
		else $error("restart changed registers");
	pin_mode_a: assert property (irq_pin_oe_out == phy_special_control[SCR_INT_OE_BIT])
		else $error("shared pin enable mismatch");
	irq_level_a: assert property ((phy_special_control[SCR_INT_EN_BIT] && !phy_special_control[SCR_INT_POL_BIT] && |(irq_src_in & irq_enable)) |-> !irq_pin_out)
		else $error("interrupt not asserted at once");
	status_set_a: assert property ((irq_src_in[0] && irq_enable[0] && !regs_default) |=> irq_status[0])
		else $error("status bit not set");
	read_clear_a: assert property ((reg_rd && reg_addr == ADDR_IRQ_STATUS_ONE && !regs_default && !(|(irq_src_in[7:0] & irq_enable[7:0]))) |=> irq_status[7:0] == 8'h00)
		else $error("read did not clear status");
	pin_powerdown_a: assert property ((!phy_special_control[SCR_INT_OE_BIT] && !irq_pin_in) |=> powerdown_out)
		else $error("pin low did not power down");
	psave_sel_a: assert property ((phy_special_control[SCR_PSAVE_EN_BIT] && psave_sel == PSAVE_PASSIVE &&
		!basic_mode_control[BMC_POWER_DOWN_BIT] && irq_pin_in) |=> low_power_passive_out && !powerdown_out)
		else $error("passive saving not selected");
	resume_a: assert property ((psave_sel == 2'h0 && !basic_mode_control[BMC_POWER_DOWN_BIT] && irq_pin_in) |=>
		!powerdown_out && !low_power_active_out && !low_power_passive_out)
		else $error("did not resume from power-save");

endmodule

// *** core/phy_rst_pkg.sv ***
package phy_rst_pkg;

	// ==========================================================================
	// Timing
	// ==========================================================================
	localparam int CLK_PERIOD_NS       = 40;
	localparam int HW_PULSE_MIN_NS     = 1000;
	localparam int HW_PULSE_MIN_CYCLES = (HW_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SETTLE_TIME_NS      = 200000;
	localparam int SETTLE_DEF_CYCLES   = SETTLE_TIME_NS / CLK_PERIOD_NS;

	// ==========================================================================
	// Register offsets
	// ==========================================================================
	localparam logic [4:0] ADDR_BASIC_MODE_CONTROL = 5'h00;
	localparam logic [4:0] ADDR_STD_LAST           = 5'h07;
	localparam logic [4:0] ADDR_PHY_SPECIAL_CONTROL = 5'h11;
	localparam logic [4:0] ADDR_IRQ_STATUS_ONE     = 5'h12;
	localparam logic [4:0] ADDR_IRQ_STATUS_TWO     = 5'h13;
	localparam logic [4:0] ADDR_PHY_RESET_CONTROL  = 5'h1F;

	// ==========================================================================
	// Field positions and reset values
	// ==========================================================================
	localparam int BMC_SOFT_RESET_BIT   = 15;
	localparam int BMC_POWER_DOWN_BIT   = 11;
	localparam int RCR_GLOBAL_RESET_BIT = 15;
	localparam int RCR_RESTART_BIT      = 14;
	localparam int SCR_INT_OE_BIT       = 0;
	localparam int SCR_INT_EN_BIT       = 1;
	localparam int SCR_INT_POL_BIT      = 2;
	localparam int SCR_PSAVE_EN_BIT     = 14;
	localparam int SCR_PSAVE_SEL_LSB    = 12;

	localparam logic [15:0] BMC_RESET_VALUE  = 16'h0000;
	localparam logic [15:0] SCR_RESET_VALUE  = 16'h0000;
	localparam logic [15:0] RCR_RESET_VALUE  = 16'h0000;
	localparam logic [15:0] IRQ_EN_RESET     = 16'h0000;
	localparam logic [4:0]  STRAP_RESET      = 5'h00;

	localparam logic [1:0] PSAVE_POWER_DOWN = 2'h1;
	localparam logic [1:0] PSAVE_ACTIVE     = 2'h2;
	localparam logic [1:0] PSAVE_PASSIVE    = 2'h3;

	// ==========================================================================
	// Management frame
	// ==========================================================================
	localparam logic [1:0] MGMT_OP_READ   = 2'h2;
	localparam logic [1:0] MGMT_OP_WRITE  = 2'h1;
	localparam logic [4:0] MGMT_HDR_LAST  = 5'h0B;
	localparam logic [4:0] MGMT_TA_FIRST  = 5'h0C;
	localparam logic [4:0] MGMT_DATA_LAST = 5'h1C;
	localparam logic [4:0] MGMT_FRAME_END = 5'h1D;

	typedef enum logic [2:0] {
		SEQ_RUN     = 3'b001,
		SEQ_HW_HOLD = 3'b010,
		SEQ_SETTLE  = 3'b100
	} seq_state_e;

	typedef enum logic [1:0] {
		MGMT_IDLE  = 2'b01,
		MGMT_FRAME = 2'b10
	} mgmt_state_e;

endpackage

// *** verification/mgmt_master.sv ***
`timescale 1ns/10ps
// ==========================================
// Management controller model
// The clock stands low between frames, and the line floats to its pull-up level once released.
module mgmt_master (
	input  wire logic clk_in,
	input  wire logic mdio_in,
	output logic      mdc_out,
	output logic      mdio_out,
	output logic      mdio_oe_out
);
	initial begin
		mdc_out = 1'b0;
		mdio_out = 1'b1;
		mdio_oe_out = 1'b0;
	end
	task automatic xfer(input logic [1:0] op, input logic [4:0] phy, input logic [4:0] ra,
		input logic [15:0] wd, output logic [15:0] rd);
		logic [31:0] f;
		f = {2'b01, op, phy, ra, 2'b10, wd};
		rd = 16'h0000;
		for (int i = -1; i < 33; i++) begin
			@(negedge clk_in);
			mdc_out <= 1'b0;
			mdio_oe_out <= (i < 14 || op == 2'h1) && i < 32;
			mdio_out <= (i < 0 || i > 31) ? 1'b1 : f[31 - i];
			repeat (3) @(negedge clk_in);
			if (i > 15 && i < 32) rd = {rd[14:0], mdio_in};
			mdc_out <= 1'b1;
			repeat (2) @(negedge clk_in);
		end
		@(negedge clk_in);
		mdc_out <= 1'b0;
		mdio_oe_out <= 1'b0;
	endtask
endmodule

// *** verification/testbench.sv ***
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin errors++; \
	$display("mismatch t=%0t got %h exp %h", $time, g, e); end end
// ==========================================
// Self-checking bench
module testbench import phy_rst_pkg::*; ;
	localparam int ST = 20;
	logic        clk, rst_n, hw_n, mdc, h_mdio, h_oe, d_mdio, d_oe;
	logic        pin_low, pin_o, pin_oe, pd, lpa, lpp, core_rst;
	logic [4:0]  strap, strap_q, phy, ad[6];
	logic [15:0] src, rd, v;
	logic [7:0]  m;
	int          errors, n_checks, j;
	wire         mdio = d_oe ? d_mdio : (h_oe ? h_mdio : 1'b1);
	wire         pin = pin_oe ? pin_o : !pin_low;

	phy_reset_powerdown_interrupt #(.SETTLE_CYCLES(ST)) dut (.sys_clk_in(clk), .reset_n_in(rst_n),
		.hw_reset_n_in(hw_n), .strap_in(strap), .mdc_in(mdc), .mdio_in(mdio), .mdio_out(d_mdio),
		.mdio_oe_out(d_oe), .irq_src_in(src), .irq_pin_in(pin), .irq_pin_out(pin_o),
		.irq_pin_oe_out(pin_oe), .core_reset_out(core_rst), .powerdown_out(pd),
		.low_power_active_out(lpa), .low_power_passive_out(lpp), .strap_out(strap_q));
	mgmt_master host (.clk_in(clk), .mdio_in(mdio), .mdc_out(mdc), .mdio_out(h_mdio), .mdio_oe_out(h_oe));

	function automatic logic [2:0] ps_exp(input logic en, input logic [1:0] s);
		return en ? {s == 2'h1, s == 2'h2, s == 2'h3} : 3'h0;
	endfunction
	task automatic cyc(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		logic [15:0] x;
		host.xfer(MGMT_OP_WRITE, phy, a, d, x);
		cyc(4);
	endtask
	task automatic rd_chk(input logic [4:0] a, input logic [15:0] e);
		host.xfer(MGMT_OP_READ, phy, a, 16'h0000, rd);
		`CHK(rd, e)
	endtask
	task automatic tally_and_finish;
		if (errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		cyc(60000);
		errors++;
		tally_and_finish();
	end
	initial begin
		void'($urandom(32'h6e00bdbd));
		ad = '{5'h00, 5'h11, 5'h12, 5'h13, 5'h1F, 5'h05};
		{rst_n, hw_n, pin_low, src} = {3'b010, 16'h0000};
		strap = 5'($urandom());
		phy = strap;
		cyc(8);
		rst_n = 1'b1;
		cyc(4);
		`CHK(strap_q, strap)
		`CHK(pin_oe, 1'b0)
		foreach (ad[i]) rd_chk(ad[i], 16'h0000);
		pin_low = 1'b1;
		cyc(4);
		`CHK(pd, 1'b1)
		pin_low = 1'b0;
		cyc(4);
		`CHK(pd, 1'b0)
		wr(5'h00, 16'h0800);
		`CHK(pd, 1'b1)
		rd_chk(5'h00, 16'h0800);
		wr(5'h11, 16'h0007);
		wr(5'h00, 16'h8000);
		cyc(ST + 4);
		`CHK(pd, 1'b0)
		rd_chk(5'h11, 16'h0007);
		`CHK(pin_o, 1'b0)
		for (int s = 0; s < 8; s++) begin
			wr(5'h11, {1'b0, 3'(s), 12'h000});
			`CHK({pd, lpa, lpp}, ps_exp(s[2], s[1:0]))
		end
		wr(5'h11, 16'h4000);
		`CHK({pd, lpa, lpp}, 3'h0)
		wr(5'h11, 16'h0003);
		`CHK(pin_oe, 1'b1)
		for (int r = 0; r < 2; r++) begin
			j = $urandom_range(0, 7);
			m = 8'($urandom()) | (8'h01 << j);
			wr(5'(ADDR_IRQ_STATUS_ONE + r), {8'h00, m});
			src[8 * r + j] = 1'b1;
			#1;
			`CHK(pin_o, 1'b0)
			cyc(1);
			src = 16'h0000;
			rd_chk(5'(ADDR_IRQ_STATUS_ONE + r), {8'h01 << j, m});
			`CHK(pin_o, 1'b1)
			rd_chk(5'(ADDR_IRQ_STATUS_ONE + r), {8'h00, m});
		end
		v = {2'b00, 14'($urandom())};
		wr(5'h1F, v);
		wr(5'h1F, v | 16'h4000);
		`CHK(core_rst, 1'b1)
		cyc(ST);
		`CHK(core_rst, 1'b0)
		rd_chk(5'h1F, v);
		rd_chk(5'h11, 16'h0003);
		strap = ~phy;
		wr(5'h1F, 16'h8000);
		`CHK(core_rst, 1'b1)
		cyc(ST + 4);
		`CHK(strap_q, phy)
		foreach (ad[i]) rd_chk(ad[i], 16'h0000);
		wr(5'h11, 16'h0001);
		hw_n = 1'b0;
		cyc(HW_PULSE_MIN_CYCLES - 1);
		hw_n = 1'b1;
		cyc(2);
		`CHK(core_rst, 1'b0)
		hw_n = 1'b0;
		cyc(HW_PULSE_MIN_CYCLES + 1);
		`CHK(core_rst, 1'b1)
		hw_n = 1'b1;
		cyc(ST - 2);
		`CHK(core_rst, 1'b1)
		cyc(6);
		`CHK(core_rst, 1'b0)
		`CHK(strap_q, strap)
		phy = strap;
		cyc(6);
		rd_chk(5'h11, 16'h0000);
		tally_and_finish();
	end
endmodule
